// *** rtl/ext_line_sel_pkg.sv ***
// constants and carriers for the external line source selector bank
// assumes a 32-bit axi4-lite register bus and six gpio ports of 16 pins
package ext_line_sel_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFF_SEL_4_TO_7   = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_SEL_8_TO_11  = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_SEL_12_TO_15 = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_COMP_CTRL    = 6'h20;

  localparam logic [DATA_W-1:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [15:0]       SEL_MASK    = 16'hffff;
  localparam int unsigned       COMP_EN_BIT  = 0;
  localparam int unsigned       COMP_RDY_BIT = 8;

  localparam int unsigned NIBBLE_W  = 4;
  localparam int unsigned FIRST_LINE = 4;
  localparam int unsigned NUM_LINES  = 12;
  localparam int unsigned LINES_PER_REG = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SRC_PORT_A = 4'h0,
    SRC_PORT_B = 4'h1,
    SRC_PORT_C = 4'h2,
    SRC_PORT_D = 4'h3,
    SRC_PORT_E = 4'h4,
    SRC_PORT_H = 4'h7
  } port_code_e;

  // pin levels of the six selectable ports, bit x is pin x
  typedef struct packed {
    logic [15:0] port_h;
    logic [15:0] port_e;
    logic [15:0] port_d;
    logic [15:0] port_c;
    logic [15:0] port_b;
    logic [15:0] port_a;
  } port_pins_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0]        strb;
  } wr_req_s;

endpackage

// *** rtl/pin_sync2.sv ***
// two-flop synchroniser for a bus of pins
// assumes the pins are asynchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
  parameter int unsigned W = 96
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** rtl/ext_line_sel_regs.sv ***
// external line source selector and compensation cell control registers
// assumes axi4-lite master on aclk; port pins and cell ready are async
//
// Function
// - lines 4-7 selected by nibbles, register one
// - lines 8-11 selected by nibbles, register two
// - lines 12-15 selected by nibbles, register three
// - all registers reset zero; upper bits reserved
// - bit 0 enables or powers down cell
// - bit 8 reads compensation cell ready
// - codes map to ports A-E and H
`timescale 1ns/1ps
`default_nettype none
module ext_line_sel_regs (
  // clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // axi4-lite write address
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [ext_line_sel_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                     s_axi_awprot,
  // axi4-lite write data
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  input  wire logic [ext_line_sel_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  // axi4-lite write response
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  output logic      [1:0]                     s_axi_bresp,
  // axi4-lite read address
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  input  wire logic [ext_line_sel_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                     s_axi_arprot,
  // axi4-lite read data
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  output logic      [ext_line_sel_pkg::DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]                     s_axi_rresp,
  // gpio port pins and external lines 4 to 15
  input  wire ext_line_sel_pkg::port_pins_s   port_pins,
  output logic      [15:0]                    ext_line_out,
  // compensation cell
  input  wire logic                           comp_cell_ready_in,
  output logic                                comp_cell_enable
);
  import ext_line_sel_pkg::*;

  logic [15:0] sel_4_7_reg;
  logic [15:0] sel_8_11_reg;
  logic [15:0] sel_12_15_reg;
  logic        comp_en_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  wr_req_s     wr_reg;
  logic        rdy_meta_reg;
  logic        rdy_sync_reg;
  port_pins_s  pins_sync;
  logic        wr_fire;
  logic        rd_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic [15:0] line_next;
  logic [NIBBLE_W-1:0] line_code;
  int unsigned         line_num;
  logic        aw_take;
  logic        w_take;
  logic        aw_held_next;
  logic        w_held_next;
  logic        b_valid_next;
  logic        r_valid_next;
  logic [DATA_W-1:0] rd_word;

  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    return (a == OFF_SEL_4_TO_7) || (a == OFF_SEL_8_TO_11) ||
           (a == OFF_SEL_12_TO_15) || (a == OFF_COMP_CTRL);
  endfunction

  // byte-lane merge for the low half word of a selector register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [DATA_W-1:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0]  = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  // pick pin x of the port named by code, reserved codes give low
  function automatic logic pick_pin(input logic [NIBBLE_W-1:0] code,
                                    input port_pins_s p,
                                    input int unsigned x);
    logic v;
    case (code)
      SRC_PORT_A: v = p.port_a[x];
      SRC_PORT_B: v = p.port_b[x];
      SRC_PORT_C: v = p.port_c[x];
      SRC_PORT_D: v = p.port_d[x];
      SRC_PORT_E: v = p.port_e[x];
      SRC_PORT_H: v = p.port_h[x];
      default:    v = 1'b0;
    endcase
    return v;
  endfunction

  function automatic logic [NIBBLE_W-1:0] nibble_of(input logic [15:0] r,
                                                    input int unsigned k);
    return r[k*NIBBLE_W +: NIBBLE_W];
  endfunction

  pin_sync2 #(
    .W ($bits(port_pins_s))
  ) u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (port_pins),
    .sync_out (pins_sync)
  );

  // write channel: address and data taken in either order, then answered
  // readies are flops, worked out from the next handshake state so that
  // they still drop in the same cycle as bvalid rises
  assign aw_take      = s_axi_awvalid && s_axi_awready;
  assign w_take       = s_axi_wvalid && s_axi_wready;
  assign aw_held_next = !wr_fire && (aw_held_reg || aw_take);
  assign w_held_next  = !wr_fire && (w_held_reg || w_take);
  assign b_valid_next = wr_fire || (s_axi_bvalid && !s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      s_axi_awready <= !aw_held_next && !b_valid_next;
      s_axi_wready  <= !w_held_next && !b_valid_next;
    end
  end

  assign wr_addr = aw_held_reg ? wr_reg.addr : s_axi_awaddr;
  assign wr_data = w_held_reg  ? wr_reg.data : s_axi_wdata;
  assign wr_strb = w_held_reg  ? wr_reg.strb : s_axi_wstrb;
  assign wr_fire = (aw_held_reg || aw_take) && (w_held_reg || w_take);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
    end
  end

  // a half that arrives alone is kept until its partner comes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_reg <= '0;
    end else begin
      if (aw_take) begin
        wr_reg.addr <= s_axi_awaddr;
      end
      if (w_take) begin
        wr_reg.data <= s_axi_wdata;
        wr_reg.strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known_addr(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // selector and control registers, reserved bits never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_4_7_reg <= RESET_VALUE[15:0];
    end else if (wr_fire && wr_addr == OFF_SEL_4_TO_7) begin
      sel_4_7_reg <= merge16(sel_4_7_reg, wr_data, wr_strb);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_8_11_reg <= RESET_VALUE[15:0];
    end else if (wr_fire && wr_addr == OFF_SEL_8_TO_11) begin
      sel_8_11_reg <= merge16(sel_8_11_reg, wr_data, wr_strb);
    end
  end

  // code 1000 on lines 12-15 is left to software to avoid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_12_15_reg <= RESET_VALUE[15:0];
    end else if (wr_fire && wr_addr == OFF_SEL_12_TO_15) begin
      sel_12_15_reg <= merge16(sel_12_15_reg, wr_data, wr_strb);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_en_reg <= RESET_VALUE[COMP_EN_BIT];
    end else if (wr_fire && wr_addr == OFF_COMP_CTRL && wr_strb[0]) begin
      comp_en_reg <= wr_data[COMP_EN_BIT];
    end
  end

  // read channel, one cycle from address to data
  assign rd_fire      = s_axi_arvalid && s_axi_arready;
  assign r_valid_next = rd_fire || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !r_valid_next;
    end
  end

  // word of the addressed register; reserved bits read zero
  always_comb begin
    rd_word = RESET_VALUE;
    case (s_axi_araddr)
      OFF_SEL_4_TO_7:   rd_word[15:0] = sel_4_7_reg & SEL_MASK;
      OFF_SEL_8_TO_11:  rd_word[15:0] = sel_8_11_reg;
      OFF_SEL_12_TO_15: rd_word[15:0] = sel_12_15_reg;
      OFF_COMP_CTRL: begin
        rd_word[COMP_EN_BIT]  = comp_en_reg;
        rd_word[COMP_RDY_BIT] = rdy_sync_reg;
      end
      default: ;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= RESET_VALUE;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata  <= rd_word;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ready flag comes from the analog cell, so it is synchronised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdy_meta_reg <= 1'b0;
      rdy_sync_reg <= 1'b0;
    end else begin
      rdy_meta_reg <= comp_cell_ready_in;
      rdy_sync_reg <= rdy_meta_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_cell_enable <= 1'b0;
    end else begin
      comp_cell_enable <= comp_en_reg;
    end
  end

  // line routing; lines 0 to 3 belong elsewhere and stay low
  always_comb begin
    line_next = '0;
    line_code = '0;
    line_num  = 0;
    for (int unsigned i = 0; i < NUM_LINES; i++) begin
      line_num = i + FIRST_LINE;
      case (i / LINES_PER_REG)
        0:       line_code = nibble_of(sel_4_7_reg, i % LINES_PER_REG);
        1:       line_code = nibble_of(sel_8_11_reg, i % LINES_PER_REG);
        default: line_code = nibble_of(sel_12_15_reg, i % LINES_PER_REG);
      endcase
      line_next[line_num] = pick_pin(line_code, pins_sync, line_num);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_line_out <= '0;
    end else begin
      ext_line_out <= line_next;
    end
  end

endmodule
`default_nettype wire

// *** verification/ext_line_sel_asserts.sv ***
// bus handshake and output checks for the line selector bank
// assumes one clock, aclk, and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module ext_line_sel_asserts (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // outputs
  input wire logic [15:0] ext_line_out,
  input wire logic        comp_cell_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  b_after_wr_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped");
  b_clear_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("bvalid stuck");
  aw_block_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("aw taken early");
  r_after_ar_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no rvalid");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("ar taken early");
  low_lines_a: assert property (ext_line_out[3:0] == 4'h0)
    else $error("lines 0-3 driven");
  rst_zero_a: assert property (disable iff (1'b0) !aresetn
    |=> !comp_cell_enable && ext_line_out == 16'h0 && !s_axi_bvalid
    && !s_axi_rvalid) else $error("reset values wrong");
endmodule

bind ext_line_sel_regs ext_line_sel_asserts ext_line_sel_asserts_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .ext_line_out(ext_line_out), .comp_cell_enable(comp_cell_enable));
`default_nettype wire

// *** verification/ext_line_sel_regs_test.sv ***
// self-checking bench for the line selector and compensation registers
// drives the axi4-lite slave, pins and cell ready directly
`timescale 1ns/1ps
`default_nettype none
module ext_line_sel_regs_test;
  import ext_line_sel_pkg::*;
  logic aclk = 0, aresetn = 0, rdy = 0, en;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic awr, wr_r, bv, arr, rv;
  logic [5:0] awa = 0, ara = 0;
  logic [2:0] awp = 0, arp = 0;
  logic [31:0] wd = 0, rd_d;
  logic [3:0] ws = 0;
  logic [1:0] br, rr;
  logic [15:0] lines, m [3];
  port_pins_s pins = '0;
  int fail_count = 0, checks = 0;

  ext_line_sel_regs ext_line_sel_regs_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_awprot(awp), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(arp),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd_d),
    .s_axi_rresp(rr), .port_pins(pins), .ext_line_out(lines),
    .comp_cell_ready_in(rdy), .comp_cell_enable(en));

  initial forever #20 aclk = ~aclk;

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic finish_test;
    $display("mismatches %0d of %0d checks", fail_count, checks);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // caller returns just after an edge; first edge keeps drives apart
  task automatic wr(logic [5:0] a, logic [31:0] d, logic [3:0] s,
                    logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    ws <= s;
    awp <= 3'($urandom);
    awv <= 1;
    wv <= 1;
    bre <= 1;
    // each channel is released at the edge that takes it
    do begin
      @(posedge aclk);
      if (awr) aw_done = 1;
      if (wr_r) w_done = 1;
      if (aw_done) awv <= 0;
      if (w_done) wv <= 0;
    end while (!(aw_done && w_done));
    do @(posedge aclk); while (!bv);
    bre <= 0;
    chk("bresp", 32'(br), 32'(r));
  endtask

  task automatic rd(logic [5:0] a, logic [31:0] e, logic [1:0] r);
    @(posedge aclk);
    ara <= a;
    arp <= 3'($urandom);
    arv <= 1;
    rre <= 1;
    do @(posedge aclk); while (!arr);
    arv <= 0;
    do @(posedge aclk); while (!rv);
    rre <= 0;
    chk("rdata", rd_d, e);
    chk("rresp", 32'(rr), 32'(r));
  endtask

  task automatic sel(int i, logic [31:0] d, logic [3:0] s);
    // software never selects the missing upper port i pins
    if (i == 2) for (int k = 0; k < 16; k += 4)
      if (d[k+:4] == 4'h8) d[k] = 1'b1;
    wr(OFF_SEL_4_TO_7 + 6'(4 * i), d, s, RESP_OKAY);
    if (s[0]) m[i][7:0] = d[7:0];
    if (s[1]) m[i][15:8] = d[15:8];
  endtask

  function automatic logic [15:0] exp_lines(port_pins_s p);
    logic [15:0] v;
    logic [3:0] c;
    v = 16'h0;
    for (int x = 4; x < 16; x++) begin
      c = m[(x - 4) / 4][(x % 4) * 4 +: 4];
      case (c)
        4'h0: v[x] = p.port_a[x];
        4'h1: v[x] = p.port_b[x];
        4'h2: v[x] = p.port_c[x];
        4'h3: v[x] = p.port_d[x];
        4'h4: v[x] = p.port_e[x];
        4'h7: v[x] = p.port_h[x];
        default: v[x] = 1'b0;
      endcase
    end
    return v;
  endfunction

  // pins are two flops plus the output flop from the line
  task automatic pin_chk;
    pins <= {$urandom, $urandom, $urandom};
    repeat (4) @(posedge aclk);
    chk("lines", 32'(lines), 32'(exp_lines(pins)));
  endtask

  task automatic zeros;
    logic [5:0] offs [4];
    offs = '{OFF_SEL_4_TO_7, OFF_SEL_8_TO_11, OFF_SEL_12_TO_15, OFF_COMP_CTRL};
    for (int i = 0; i < 4; i++) rd(offs[i], RESET_VALUE, RESP_OKAY);
    for (int i = 0; i < 3; i++) m[i] = 16'h0;
    pin_chk;
    chk("enable", 32'(en), 32'h0);
  endtask

  initial begin
    void'($urandom(53007));
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    zeros;
    rd(6'h3c, 32'h0, RESP_SLVERR);
    wr(6'h3c, 32'hffffffff, 4'hf, RESP_SLVERR);
    for (int c = 0; c < 16; c++) begin
      for (int i = 0; i < 3; i++) sel(i, {16'($urandom), {4{4'(c)}}}, 4'hf);
      pin_chk;
    end
    repeat (24) begin
      int i;
      i = $urandom_range(2);
      sel(i, $urandom, 4'($urandom));
      rd(OFF_SEL_4_TO_7 + 6'(4 * i), {16'h0, m[i]}, RESP_OKAY);
      pin_chk;
    end
    for (int v = 1; v >= 0; v--) begin
      rdy <= 1'(!v);
      wr(OFF_COMP_CTRL, 32'hfffffffe | 32'(v), 4'h1, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("enable", 32'(en), 32'(v));
      rd(OFF_COMP_CTRL, 32'(v) | (32'(!v) << 8), RESP_OKAY);
    end
    aresetn <= 0;
    rdy <= 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    zeros;
    finish_test;
  end

  initial begin
    #2000000;
    fail_count++;
    finish_test;
  end
endmodule
`default_nettype wire
